// *** tap_pkg.sv ***
// Shared constants and types for the SRAM boundary-scan test access port.
package tap_pkg;

  // Instruction register geometry and codes.
  localparam int IR_WIDTH = 3;
  localparam logic [2:0] CODE_EXTEST = 3'h0;
  localparam logic [2:0] CODE_IDCODE = 3'h1;
  localparam logic [2:0] CODE_SAMPLE_Z = 3'h2;
  localparam logic [2:0] CODE_RESERVED = 3'h3;
  localparam logic [2:0] CODE_SAMPLE = 3'h4;
  localparam logic [2:0] CODE_PRIVATE = 3'h5;
  localparam logic [2:0] CODE_RESERVED_FUTURE = 3'h6;
  localparam logic [2:0] CODE_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // Identification register layout.
  localparam int ID_WIDTH = 32;
  localparam int ID_VENDOR_LSB = 1;
  localparam int ID_VENDOR_WIDTH = 11;
  localparam int ID_UNUSED_WIDTH = 20;
  localparam logic [19:0] ID_UNUSED_VALUE = 20'h00000;
  localparam logic ID_PRESENCE = 1'b1;

  // Boundary register cells that face no pin.
  localparam logic PLACEHOLDER_VALUE = 1'b1;

  // Consecutive high mode-select samples that always reach test-logic reset.
  localparam int TLR_ONES = 5;

  // Stages of every synchroniser.
  localparam int SYNC_STAGES = 3;

  typedef enum logic [15:0] {
    TLR = 16'h0001,
    RTI = 16'h0002,
    SEL_DR = 16'h0004,
    CAP_DR = 16'h0008,
    SH_DR = 16'h0010,
    EX1_DR = 16'h0020,
    PA_DR = 16'h0040,
    EX2_DR = 16'h0080,
    UP_DR = 16'h0100,
    SEL_IR = 16'h0200,
    CAP_IR = 16'h0400,
    SH_IR = 16'h0800,
    EX1_IR = 16'h1000,
    PA_IR = 16'h2000,
    EX2_IR = 16'h4000,
    UP_IR = 16'h8000
  } tap_state_t;

endpackage

// *** word_xfer_if.sv ***
// Word carrier between a clock-domain crossing and its user.
interface word_xfer_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] srcWord;
  logic [WIDTH-1:0] dstWord;
  logic dstNew;
  modport xfer (input srcWord, output dstWord, output dstNew);
  modport user (output srcWord, input dstWord, input dstNew);
endinterface

// *** word_xfer.sv ***
// Toggle handshake that carries a word from one clock domain to another.
module word_xfer
  import tap_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic srcClk, // Source clock.
  input wire logic srcRst, // Source synchronous reset, active high.
  input wire logic srcEn, // Source clock enable.
  input wire logic dstClk, // Destination clock.
  input wire logic dstRst, // Destination synchronous reset, active high.
  input wire logic dstEn, // Destination clock enable.
  word_xfer_if.xfer port // Source word in, destination word out.
);

  logic [WIDTH-1:0] hold;
  logic busy;
  logic reqTgl;
  logic ackTgl;
  logic [SYNC_STAGES-1:0] ackSync;
  logic [SYNC_STAGES-1:0] reqSync;

  // The held word stays still from the request toggle until the acknowledge returns.
  wire ackBack = (ackSync[1] == ackSync[2]) && (ackSync[2] == reqTgl);
  wire newReq = (reqSync[1] == reqSync[2]) && (reqSync[2] != ackTgl);

  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      hold <= '0;
      busy <= 1'b0;
      reqTgl <= 1'b0;
      ackSync <= '0;
    end else if (srcEn) begin
      ackSync <= {ackSync[1:0], ackTgl};
      if (!busy) begin
        hold <= port.srcWord;
        reqTgl <= ~reqTgl;
        busy <= 1'b1;
      end else if (ackBack) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      reqSync <= '0;
      ackTgl <= 1'b0;
      port.dstWord <= '0;
      port.dstNew <= 1'b0;
    end else if (dstEn) begin
      reqSync <= {reqSync[1:0], reqTgl};
      port.dstNew <= newReq;
      if (newReq) begin
        port.dstWord <= hold;
        ackTgl <= reqSync[2];
      end
    end
  end

endmodule // word_xfer

// *** sram_boundary_scan_tap.sv ***
// Test access port with instruction decode and bypass, ID and boundary registers.
module sram_boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int PIN_COUNT = 16,
  parameter int OUT_COUNT = 8,
  parameter int FILL_COUNT = 4,
  parameter logic [10:0] VENDOR_CODE = 11'h2A5 // Arbitrary neutral value.
) (
  input wire logic clk, // Memory-side clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable for the memory-side logic.
  input wire logic tck, // Test clock.
  input wire logic tms, // Test mode select.
  input wire logic tdi, // Serial test data in.
  output logic tdo, // Serial test data out.
  output logic tdoEnable, // High while the serial output is driven.
  input wire logic [PIN_COUNT-1:0] pinLevel, // Input and I/O pin levels.
  output logic [OUT_COUNT-1:0] testDriveValue, // Boundary values for output drivers.
  output logic testDriveEnable, // Output drivers take the boundary values.
  output logic outputsHighZ // All memory outputs float.
);

  localparam int BSR_LEN = PIN_COUNT + FILL_COUNT;
  localparam int CTL_WIDTH = OUT_COUNT + 2;

  if (PIN_COUNT < 1 || OUT_COUNT < 1 || OUT_COUNT > PIN_COUNT || FILL_COUNT < 1) begin : g_check
    $error("Pin, output or filler count out of range.");
  end

  // Power-up reset of the test domain, later also carried from srst.
  logic [SYNC_STAGES-1:0] rstSync = '1;
  logic tckRst = 1'b1;

  tap_state_t state;
  tap_state_t next_state;
  logic [IR_WIDTH-1:0] irShift;
  logic [IR_WIDTH-1:0] instr;
  logic bypassBit;
  logic [ID_WIDTH-1:0] idReg;
  logic [BSR_LEN-1:0] bsr;
  logic [OUT_COUNT-1:0] updLatch;
  logic [PIN_COUNT-1:0] pinStable;

  word_xfer_if #(.WIDTH(PIN_COUNT)) pinBus ();
  word_xfer_if #(.WIDTH(CTL_WIDTH)) ctlBus ();

  // Decoding of the active instruction.
  wire extestActive = (instr == CODE_EXTEST);
  wire sampleActive = (instr == CODE_SAMPLE);
  wire sampleZActive = (instr == CODE_SAMPLE_Z);
  wire idSel = (instr == CODE_IDCODE);
  wire bsrSel = extestActive || sampleActive || sampleZActive;
  wire bypassSel = !idSel && !bsrSel;
  wire shiftNow = (state == SH_IR) || (state == SH_DR);
  wire captureDr = (state == CAP_DR);
  wire shiftDr = (state == SH_DR);

  wire [ID_WIDTH-1:0] idValue = {ID_UNUSED_VALUE, VENDOR_CODE, ID_PRESENCE};
  wire [BSR_LEN-1:0] bsrCapture = {{FILL_COUNT{PLACEHOLDER_VALUE}}, pinBus.dstWord};

  wire serialBit = (state == SH_IR) ? irShift[0] :
                   idSel ? idReg[0] :
                   bsrSel ? bsr[0] : bypassBit;

  // Test-domain reset: power-up value, then srst through three stages.
  always_ff @(posedge tck) begin
    rstSync <= {rstSync[1:0], srst};
    if (rstSync[1] == rstSync[2]) begin
      tckRst <= rstSync[2];
    end
  end

  // Controller transitions on the sampled mode-select level.
  always_comb begin
    next_state = TLR;
    unique case (state)
      TLR: next_state = tms ? TLR : RTI;
      RTI: next_state = tms ? SEL_DR : RTI;
      SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
      CAP_DR: next_state = tms ? EX1_DR : SH_DR;
      SH_DR: next_state = tms ? EX1_DR : SH_DR;
      EX1_DR: next_state = tms ? UP_DR : PA_DR;
      PA_DR: next_state = tms ? EX2_DR : PA_DR;
      EX2_DR: next_state = tms ? UP_DR : SH_DR;
      UP_DR: next_state = tms ? SEL_DR : RTI;
      SEL_IR: next_state = tms ? TLR : CAP_IR;
      CAP_IR: next_state = tms ? EX1_IR : SH_IR;
      SH_IR: next_state = tms ? EX1_IR : SH_IR;
      EX1_IR: next_state = tms ? UP_IR : PA_IR;
      PA_IR: next_state = tms ? EX2_IR : PA_IR;
      EX2_IR: next_state = tms ? UP_IR : SH_IR;
      UP_IR: next_state = tms ? SEL_DR : RTI;
      default: next_state = TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tckRst) begin
      state <= TLR;
    end else begin
      state <= next_state;
    end
  end

  // Instruction shift stage; the active instruction is not touched here.
  always_ff @(posedge tck) begin
    if (tckRst) begin
      irShift <= IR_CAPTURE;
    end else if (state == CAP_IR) begin
      irShift <= IR_CAPTURE;
    end else if (state == SH_IR) begin
      irShift <= {tdi, irShift[IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tckRst) begin
      bypassBit <= 1'b0;
    end else if (captureDr && bypassSel) begin
      bypassBit <= 1'b0;
    end else if (shiftDr && bypassSel) begin
      bypassBit <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (tckRst) begin
      idReg <= '0;
    end else if (captureDr && idSel) begin
      idReg <= idValue;
    end else if (shiftDr && idSel) begin
      idReg <= {tdi, idReg[ID_WIDTH-1:1]};
    end
  end

  // Pin levels come from the memory domain through a handshake.
  always_ff @(posedge tck) begin
    if (tckRst) begin
      bsr <= '0;
    end else if (captureDr && bsrSel) begin
      bsr <= bsrCapture;
    end else if (shiftDr && bsrSel) begin
      bsr <= {tdi, bsr[BSR_LEN-1:1]};
    end
  end

  // Falling-edge logic: instruction update, output latch and serial output.
  always_ff @(negedge tck) begin
    if (tckRst || state == TLR) begin
      instr <= CODE_IDCODE;
    end else if (state == UP_IR) begin
      instr <= irShift;
    end
  end

  always_ff @(negedge tck) begin
    if (tckRst) begin
      updLatch <= '0;
    end else if (state == UP_DR && bsrSel) begin
      updLatch <= bsr[OUT_COUNT-1:0];
    end
  end

  always_ff @(negedge tck) begin
    if (tckRst) begin
      tdo <= 1'b0;
      tdoEnable <= 1'b0;
    end else begin
      tdo <= shiftNow ? serialBit : 1'b0;
      tdoEnable <= shiftNow;
    end
  end

  // Memory-domain pin filter: a level counts once stages two and three agree.
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    logic [SYNC_STAGES:0] stage;
    always_ff @(posedge clk) begin
      if (srst) begin
        stage <= '0;
      end else if (ce) begin
        stage[SYNC_STAGES-1:0] <= {stage[1:0], pinLevel[i]};
        if (stage[1] == stage[2]) begin
          stage[SYNC_STAGES] <= stage[2];
        end
      end
    end
    assign pinStable[i] = stage[SYNC_STAGES];
  end

  // Sampling never feeds back into the functional pins.
  assign pinBus.srcWord = pinStable;

  word_xfer #(.WIDTH(PIN_COUNT)) u_pin_xfer (
    .srcClk(clk),
    .srcRst(srst),
    .srcEn(ce),
    .dstClk(tck),
    .dstRst(tckRst),
    .dstEn(1'b1),
    .port(pinBus)
  );

  assign ctlBus.srcWord = {sampleZActive, extestActive, updLatch};

  word_xfer #(.WIDTH(CTL_WIDTH)) u_ctl_xfer (
    .srcClk(tck),
    .srcRst(tckRst),
    .srcEn(1'b1),
    .dstClk(clk),
    .dstRst(srst),
    .dstEn(ce),
    .port(ctlBus)
  );

  // The carried word is a register in the memory domain.
  assign testDriveValue = ctlBus.dstWord[OUT_COUNT-1:0];
  assign testDriveEnable = ctlBus.dstWord[OUT_COUNT];
  assign outputsHighZ = ctlBus.dstWord[OUT_COUNT+1];

  // Checks on the test-clock side.
  default clocking cb @(posedge tck);
  endclocking
  default disable iff (tckRst);

  property p_ir_capture;
    state == CAP_IR |=> irShift[1:0] == 2'b01;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("Capture-IR pattern wrong.");

  property p_ir_shift;
    state == SH_IR |=> irShift == {$past(tdi), $past(irShift[IR_WIDTH-1:1])};
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("Instruction shift wrong.");

  property p_instr_update;
    $changed(instr) |-> (state == UP_IR || state == TLR);
  endproperty
  a_instr_update: assert property (p_instr_update) else $error("Instruction changed early.");

  property p_instr_load;
    state == UP_IR |=> instr == $past(irShift);
  endproperty
  a_instr_load: assert property (p_instr_load) else $error("Update-IR did not load.");

  property p_bypass_shift;
    shiftDr && (instr == CODE_RESERVED || instr == CODE_BYPASS) |=> bypassBit == $past(tdi);
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) else $error("Bypass path wrong.");

  property p_bsr_capture;
    captureDr && bsrSel |=> bsr[BSR_LEN-1:PIN_COUNT] == {FILL_COUNT{PLACEHOLDER_VALUE}};
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("Filler cells wrong.");

  property p_id_capture;
    captureDr && idSel |=> idReg[0] == 1'b1 && idReg[ID_WIDTH-1:12] == '0;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("ID capture wrong.");

  property p_id_order;
    shiftDr && idSel |-> tdoEnable && tdo == idReg[0];
  endproperty
  a_id_order: assert property (p_id_order) else $error("ID bit order wrong.");

  property p_tlr_entry;
    tms [*5] |=> state == TLR;
  endproperty
  a_tlr_entry: assert property (p_tlr_entry) else $error("Five ones missed reset.");

  property p_tlr_instr;
    state == TLR |-> instr == CODE_IDCODE;
  endproperty
  a_tlr_instr: assert property (p_tlr_instr) else $error("Reset instruction wrong.");

  property p_tdo_idle;
    !shiftNow |-> !tdoEnable;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle) else $error("Serial output driven idle.");

  property p_extest_flag;
    state == UP_IR && $past(state) == EX1_IR ##0 irShift == CODE_EXTEST |=> extestActive;
  endproperty
  a_extest_flag: assert property (p_extest_flag) else $error("External test not active.");

  property p_ir_out;
    state == SH_IR |-> tdo == irShift[0];
  endproperty
  a_ir_out: assert property (p_ir_out) else $error("Instruction shift-out wrong.");

  property p_ir_hold;
    state != CAP_IR && state != SH_IR |=> $stable(irShift);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("Instruction stage moved.");

  property p_bypass_capture;
    captureDr && bypassSel |=> bypassBit == 1'b0;
  endproperty
  a_bypass_capture: assert property (p_bypass_capture) else $error("Bypass capture wrong.");

  property p_bypass_private;
    shiftDr && (instr == CODE_PRIVATE || instr == CODE_RESERVED_FUTURE) |=> bypassBit == $past(tdi);
  endproperty
  a_bypass_private: assert property (p_bypass_private) else $error("Bypass alias wrong.");

  property p_bsr_pins;
    captureDr && bsrSel |=> bsr[PIN_COUNT-1:0] == $past(pinBus.dstWord);
  endproperty
  a_bsr_pins: assert property (p_bsr_pins) else $error("Pin capture wrong.");

  property p_bsr_order;
    shiftDr && bsrSel |-> tdoEnable && tdo == bsr[0];
  endproperty
  a_bsr_order: assert property (p_bsr_order) else $error("Boundary path wrong.");

  property p_vendor;
    captureDr && idSel |=> idReg[ID_VENDOR_LSB +: ID_VENDOR_WIDTH] == VENDOR_CODE;
  endproperty
  a_vendor: assert property (p_vendor) else $error("Vendor field wrong.");

  property p_tdo_shift;
    shiftNow |-> tdoEnable;
  endproperty
  a_tdo_shift: assert property (p_tdo_shift) else $error("Serial output not driven.");

  c_id_shift: cover property (captureDr && idSel ##1 shiftDr [*8]);
  c_extest: cover property (state == UP_IR ##1 extestActive);
  c_sample_z: cover property (sampleZActive && captureDr);
  c_reset_walk: cover property (!tms ##1 tms [*5] ##1 state == TLR);

endmodule // sram_boundary_scan_tap

// *** jtag_ctl_model.sv ***
// Behavioural boundary-scan controller that drives the serial test port.
module jtag_ctl_model (
  output logic tck, // Test clock, low outside frames.
  output logic tms, // Mode select.
  output logic tdi, // Serial data to the device.
  input wire logic tdo, // Serial data from the device.
  input wire logic tdoEnable // Device drives tdo.
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // Serial input is ignored outside the shift states, so it carries noise there.
  logic [31:0] noise = 32'h8364;

  function automatic logic junk();
    noise = {noise[30:0], noise[31] ^ noise[21] ^ noise[1] ^ noise[0]};
    return noise[0];
  endfunction

  // Inputs change after the falling edge; tdo is taken just before the rising edge.
  task automatic tick(input logic m, input logic d, output logic q, output logic e);
    tms = m;
    tdi = d;
    #3;
    q = tdoEnable ? tdo : ~tdo;
    e = tdoEnable;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask

  task automatic idle(input int n);
    logic q, e;
    repeat (n) tick(1'b0, junk(), q, e);
  endtask

  task automatic goReset();
    logic q, e;
    repeat (5) tick(1'b1, junk(), q, e);
    tick(1'b0, junk(), q, e);
  endtask

  // From Run-Test/Idle through capture, shift, optional pause, update and back.
  task automatic scan(input logic ir, input int n, input logic [39:0] d, input int pause,
                      output logic [39:0] q, output logic en);
    logic b, e;
    q = '0;
    en = 1'b1;
    tick(1'b1, junk(), b, e);
    if (ir) begin
      tick(1'b1, junk(), b, e);
    end
    tick(1'b0, junk(), b, e);
    tick(1'b0, junk(), b, e);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], b, e);
      q[i] = b;
      en = en & e;
    end
    if (pause > 0) begin
      tick(1'b0, junk(), b, e);
      repeat (pause) tick(1'b0, junk(), b, e);
      tick(1'b1, junk(), b, e);
    end
    tick(1'b1, junk(), b, e);
    tick(1'b0, junk(), b, e);
  endtask
endmodule // jtag_ctl_model

// *** tb.sv ***
// Self-checking bench for the boundary-scan test access port.
module tb
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

  localparam logic [10:0] VID = 11'h4D3; // Arbitrary value.
  logic clk, srst, ce, tck, tms, tdi, tdo, tdoEnable;
  logic [15:0] pinLevel;
  logic [7:0] testDriveValue;
  logic testDriveEnable, outputsHighZ;
  logic [31:0] seed = 32'h8364;
  int error_cnt = 0;
  int checked = 0;

  sram_boundary_scan_tap #(.VENDOR_CODE(VID)) dut_u (
    .clk(clk), .srst(srst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEnable(tdoEnable), .pinLevel(pinLevel), .testDriveValue(testDriveValue),
    .testDriveEnable(testDriveEnable), .outputsHighZ(outputsHighZ));

  jtag_ctl_model ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEnable(tdoEnable));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic rnd(output logic [31:0] v);
    seed = lfsr(seed);
    v = seed;
  endtask

  // Expected serial image of a 40-bit data scan under each instruction.
  function automatic logic [39:0] expDr(input logic [2:0] c, input logic [15:0] p,
                                        input logic [39:0] r);
    case (c)
      CODE_IDCODE: return {r[7:0], 20'h00000, VID, 1'b1};
      CODE_EXTEST, CODE_SAMPLE_Z, CODE_SAMPLE: return {r[19:0], {4{PLACEHOLDER_VALUE}}, p};
      default: return {r[38:0], 1'b0};
    endcase
  endfunction

  // The captured bypass bit is not compared.
  function automatic logic [39:0] expMask(input logic [2:0] c);
    case (c)
      CODE_IDCODE, CODE_EXTEST, CODE_SAMPLE_Z, CODE_SAMPLE: return 40'hFFFFFFFFFF;
      default: return 40'hFFFFFFFFFE;
    endcase
  endfunction

  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic resetAll();
    @(negedge clk);
    srst = 1'b1;
    fork
      repeat (8) @(negedge clk);
      ctl_u.idle(60);
    join
    srst = 1'b0;
    ctl_u.idle(10);
    ctl_u.goReset();
    ctl_u.idle(80);
  endtask

  task automatic loadIr(input logic [2:0] c, input int pause);
    logic [39:0] q;
    logic en;
    ctl_u.scan(1'b1, 3, {37'h0, c}, pause, q, en);
    `CHK(q[2:0], 3'h1)
    `CHK(en, 1'b1)
    #1;
    `CHK(tdoEnable, 1'b0)
  endtask

  task automatic checkDr(input logic [2:0] c, input logic [15:0] p, input logic [39:0] r);
    logic [39:0] q;
    logic en;
    ctl_u.scan(1'b0, 40, r, 0, q, en);
    `CHK(q & expMask(c), expDr(c, p, r) & expMask(c))
    `CHK(en, 1'b1)
  endtask

  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [31:0] w, w2;
    logic [15:0] p;
    logic [39:0] q, r;
    logic en;
    srst = 1'b1;
    ce = 1'b1;
    pinLevel = 16'h0000;
    resetAll();
    rnd(w);
    rnd(w2);
    checkDr(CODE_IDCODE, 16'h0000, {w2[7:0], w});
    `CHK(testDriveEnable, 1'b0)
    for (int i = 0; i < 8; i++) begin
      rnd(w);
      rnd(w2);
      p = (i == 0) ? 16'h0000 : (i == 7) ? 16'hFFFF : w2[31:16];
      @(negedge clk);
      pinLevel = p;
      ctl_u.idle(80);
      loadIr(i[2:0], 0);
      ctl_u.idle(80);
      `CHK(testDriveEnable, i == 0)
      `CHK(outputsHighZ, i == 2)
      checkDr(i[2:0], p, {w2[7:0], w});
    end
    // Preload a pattern, then an external-test load held in Pause-IR.
    loadIr(CODE_SAMPLE, 0);
    rnd(w);
    ctl_u.scan(1'b0, 20, {20'h0, w[19:0]}, 0, q, en);
    fork
      loadIr(CODE_EXTEST, 80);
      begin
        #450;
        `CHK(testDriveEnable, 1'b0)
      end
    join
    ctl_u.idle(80);
    `CHK(testDriveEnable, 1'b1)
    `CHK(testDriveValue, w[7:0])
    // With the clock enable low the memory-side outputs hold.
    @(negedge clk);
    ce = 1'b0;
    loadIr(CODE_BYPASS, 0);
    ctl_u.idle(80);
    `CHK(testDriveEnable, 1'b1)
    @(negedge clk);
    ce = 1'b1;
    ctl_u.idle(80);
    `CHK(testDriveEnable, 1'b0)
    loadIr(CODE_SAMPLE_Z, 0);
    ctl_u.idle(80);
    `CHK(outputsHighZ, 1'b1)
    ctl_u.goReset();
    ctl_u.idle(80);
    `CHK(outputsHighZ, 1'b0)
    checkDr(CODE_IDCODE, p, {w2[7:0], w});
    loadIr(CODE_EXTEST, 0);
    resetAll();
    `CHK(testDriveEnable, 1'b0)
    checkDr(CODE_IDCODE, p, {w[7:0], w2});
    wrap_up();
  end
endmodule // tb
